// ==== rtl/bir_pkg.sv ====
// Package for the bridge interrupt router: offsets, bit positions, masks.
// Assumes a 32-bit register port with byte offsets on 12 bits.
package bir_pkg;

  // Register byte offsets
  localparam logic [11:0] OFS_STATUS = 12'h600;
  localparam logic [11:0] OFS_ENABLE_CTL = 12'h604;
  localparam logic [11:0] OFS_ROUTE_DIR = 12'h608;
  localparam logic [11:0] OFS_ENABLE_CTL2 = 12'h60c;

  // Bit positions shared by status, enable and direction
  localparam int BIT_PCI_ERRLOG = 31;
  localparam int BIT_LOCAL_ERRLOG = 30;
  localparam int BIT_MASTER_PARITY = 29;
  localparam int BIT_PCI_CFGSTATUS = 28;
  localparam int BIT_DMA_LOCAL_ERR = 27;
  localparam int BIT_DMA_PCI_ERR = 26;
  localparam int BIT_DMA_RESET = 25;
  localparam int BIT_DMA_DONE = 24;
  localparam int BIT_PCI_IRQ_IN = 23;
  localparam int BIT_PCI_PARITY_ERR = 22;
  localparam int BIT_PCI_SYSTEM_ERR = 21;
  localparam int BIT_LOCAL_IRQ_IN = 20;
  localparam int BIT_MAILBOX_LO = 16;
  localparam int BIT_LOCAL_PARITY_ERR = 15;
  localparam int BIT_POWER_STATE = 14;
  localparam int BIT_OUT_POST_NOT_EMPTY = 13;
  localparam int BIT_IN_POST_NEW_ENTRY = 12;
  localparam int BIT_IN_FREE_EMPTY = 11;
  localparam int BIT_OUT_FREE_EMPTY = 10;
  localparam int BIT_IN_POST_FULL = 9;
  localparam int BIT_OUT_FREE_FULL = 8;
  localparam int BIT_SOFT_IRQ_ZERO = 0;
  localparam int BIT_SOFT_IRQ_ONE = 1;
  localparam int BIT_SOFT_IRQ_TWO = 2;
  localparam int BIT_SOFT_IRQ_THREE = 3;

  // Sticky write-one-to-clear status bits
  localparam logic [31:0] STICKY_MASK = 32'hffffd00f;
  // Live message-queue flags, read-only
  localparam logic [31:0] QUEUE_MASK = 32'h00002f00;
  // Enable bits that software may write
  localparam logic [31:0] ENABLE_WR_MASK = 32'hffffdf00;
  // Soft interrupts carry no enable bit and always route when set
  localparam logic [31:0] ENABLE_ALWAYS = 32'h0000000f;
  // Direction bits that software may write
  localparam logic [31:0] ROUTE_WR_MASK = 32'hff0f8f0f;
  // Direction bits fixed at one (toward the PCI output)
  localparam logic [31:0] ROUTE_FIXED_ONE = 32'h00102000;
  localparam logic [31:0] ENABLE_RESET = 32'h00000000;
  localparam logic [31:0] ROUTE_RESET = 32'h00000000;

  // Interrupt sources from the rest of the bridge
  typedef struct packed {
    logic pci_errlog;
    logic local_errlog;
    logic cfg_master_parity_detected;
    logic pci_cfgstatus;
    logic dma_local_error;
    logic dma_pci_error;
    logic dma_reset;
    logic dma_done;
    logic pci_irq_in;
    logic pci_parity_err;
    logic pci_system_err;
    logic local_irq_in;
    logic [3:0] mailbox;
    logic local_parity_err;
    logic power_state_change;
    logic in_post_new_entry;
    logic out_post_not_empty_flag;
    logic in_free_empty_flag;
    logic out_free_empty_flag;
    logic in_post_full_flag;
    logic out_free_full_flag;
    logic out_post_irq_mask;
  } bir_src_type;

  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } bir_req_type;

endpackage

// ==== rtl/bir_status_cell.sv ====
// One sticky interrupt status bit: hardware set, write-one clear.
// Assumes set and clear are synchronous to ref_clk.
`timescale 1ns/1ps
module bir_status_cell (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic set,
  input wire logic clr,
  output logic status
);
  // Set beats clear so an event in the clearing cycle is kept
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      status <= 1'b0;
    end else if (set) begin
      status <= 1'b1;
    end else if (clr) begin
      status <= 1'b0;
    end
  end
endmodule // bir_status_cell

// ==== rtl/bir_router.sv ====
// Interrupt router of the bridge: status, enable, direction and routing.
// Assumes sources and register port are synchronous to ref_clk.
//
// Contract
// (R1) Status bit sets when its condition asserts
// (R2) Status stays set until one written
// (R3) Clearing status leaves source's own bit
// (R4) Handler clears source bit separately
// (R5) Parity status follows enabled config bit
// (R6) Queue flags set regardless of enables
// (R7) New-entry status needs enable and post
// (R8) Enable register at 604, resets 0
// (R9) Out-post enable copies external mask field; code uses its inverse
// (R10) Soft irq 0/1 written ones set status
// (R11) Direction register at 608, 0 local
// (R12) Some directions fixed zero, local bus
// (R13) Local irq, out-post directions fixed one
// (R14) PCI irq input passes to local
// (R15) Local irq input passes to PCI
// (R16) Parity errors interrupt local bus
// (R17) System error interrupts local bus
// (R18) Queue conditions interrupt when enabled
// (R19) Routing requires enable bit set; soft irq bits 3:0 have none and route whenever set
// (R20) Soft irq 2/3 from second register
// (R21) Outputs are levels of pending sources
`timescale 1ns/1ps
module bir_router (
  input wire logic ref_clk,
  input wire logic rst,
  input wire bir_pkg::bir_src_type src,
  input wire bir_pkg::bir_req_type req,
  output logic [31:0] rdata,
  output logic rack,
  output logic local_irq_out,
  output logic pci_irq_out
);
  import bir_pkg::*;

  logic [31:0] enable_reg;
  logic [31:0] route_reg;
  logic [31:0] enable_eff;
  logic [31:0] route_eff;
  logic [31:0] sticky;
  logic [31:0] status;
  logic [31:0] trig;
  logic [31:0] clr;
  logic [31:0] pending;
  logic [31:0] next_rdata;
  logic wr_status;
  logic wr_enable;
  logic wr_route;
  logic wr_enable2;
  logic soft_zero;
  logic soft_one;
  logic soft_two;
  logic soft_three;

  // Address decode of the write strobe
  always_comb begin
    wr_status = 1'b0;
    wr_enable = 1'b0;
    wr_route = 1'b0;
    wr_enable2 = 1'b0;
    if (req.wr && req.addr == OFS_STATUS) begin
      wr_status = 1'b1;
    end else if (req.wr && req.addr == OFS_ENABLE_CTL) begin
      wr_enable = 1'b1;
    end else if (req.wr && req.addr == OFS_ROUTE_DIR) begin
      wr_route = 1'b1;
    end else if (req.wr && req.addr == OFS_ENABLE_CTL2) begin
      wr_enable2 = 1'b1;
    end
  end

  // Soft interrupt triggers are strobes only, never stored
  assign soft_zero = wr_enable & req.wdata[BIT_SOFT_IRQ_ZERO]; // R10
  assign soft_one = wr_enable & req.wdata[BIT_SOFT_IRQ_ONE]; // R10
  assign soft_two = wr_enable2 & req.wdata[BIT_SOFT_IRQ_TWO]; // R20
  assign soft_three = wr_enable2 & req.wdata[BIT_SOFT_IRQ_THREE]; // R20

  // Enable register; read-only and trigger bits are never stored
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      enable_reg <= ENABLE_RESET; // R8
    end else if (wr_enable) begin
      enable_reg <= req.wdata & ENABLE_WR_MASK; // R8
    end
  end

  // Effective enables: out-post enable is the inverse of its mask
  always_comb begin
    enable_eff = (enable_reg & ENABLE_WR_MASK) | ENABLE_ALWAYS;
    enable_eff[BIT_OUT_POST_NOT_EMPTY] = ~src.out_post_irq_mask; // R9
  end

  // Direction register with fixed bits forced on read and use
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      route_reg <= ROUTE_RESET; // R11
    end else if (wr_route) begin
      route_reg <= req.wdata & ROUTE_WR_MASK; // R11
    end
  end

  // Fixed-zero bits drop out of the mask, fixed-one bits are ORed in
  assign route_eff = (route_reg & ROUTE_WR_MASK) | ROUTE_FIXED_ONE; // R12 R13

  // Trigger vector: level sources keep setting while asserted
  always_comb begin
    trig = 32'h00000000;
    trig[BIT_PCI_ERRLOG] = src.pci_errlog; // R1
    trig[BIT_LOCAL_ERRLOG] = src.local_errlog;
    // Level: status re-sets until the config bit is cleared too
    trig[BIT_MASTER_PARITY] = src.cfg_master_parity_detected
      & enable_reg[BIT_MASTER_PARITY]; // R5
    trig[BIT_PCI_CFGSTATUS] = src.pci_cfgstatus;
    trig[BIT_DMA_LOCAL_ERR] = src.dma_local_error;
    trig[BIT_DMA_PCI_ERR] = src.dma_pci_error;
    trig[BIT_DMA_RESET] = src.dma_reset;
    trig[BIT_DMA_DONE] = src.dma_done;
    trig[BIT_PCI_IRQ_IN] = src.pci_irq_in; // R14
    trig[BIT_PCI_PARITY_ERR] = src.pci_parity_err; // R16
    trig[BIT_PCI_SYSTEM_ERR] = src.pci_system_err; // R17
    trig[BIT_LOCAL_IRQ_IN] = src.local_irq_in; // R15
    trig[BIT_MAILBOX_LO +: 4] = src.mailbox;
    trig[BIT_LOCAL_PARITY_ERR] = src.local_parity_err; // R16
    trig[BIT_POWER_STATE] = src.power_state_change;
    trig[BIT_IN_POST_NEW_ENTRY] = src.in_post_new_entry
      & enable_reg[BIT_IN_POST_NEW_ENTRY]; // R7
    trig[BIT_SOFT_IRQ_ZERO] = soft_zero;
    trig[BIT_SOFT_IRQ_ONE] = soft_one;
    trig[BIT_SOFT_IRQ_TWO] = soft_two;
    trig[BIT_SOFT_IRQ_THREE] = soft_three;
  end

  // Write-one-to-clear strobes; only this register is touched
  assign clr = wr_status ? (req.wdata & STICKY_MASK) : 32'h00000000; // R2 R3

  // One sticky cell per status bit; other positions stay zero
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_cell
      if (STICKY_MASK[gi]) begin : g_sticky
        bir_status_cell u_cell (
          .ref_clk(ref_clk),
          .rst(rst),
          .set(trig[gi]), // R1
          .clr(clr[gi]), // R2
          .status(sticky[gi])
        );
      end else begin : g_none
        assign sticky[gi] = 1'b0;
      end
    end
  endgenerate

  // Queue flags mirror the list state whatever the enables say
  always_comb begin
    status = sticky;
    status[BIT_OUT_POST_NOT_EMPTY] = src.out_post_not_empty_flag; // R6
    status[BIT_IN_FREE_EMPTY] = src.in_free_empty_flag; // R6
    status[BIT_OUT_FREE_EMPTY] = src.out_free_empty_flag; // R6
    status[BIT_IN_POST_FULL] = src.in_post_full_flag; // R6
    status[BIT_OUT_FREE_FULL] = src.out_free_full_flag; // R6
  end

  // Only enabled status bits take part in routing
  assign pending = status & enable_eff; // R19 R18

  // Registered level outputs; one cycle behind the status
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      local_irq_out <= 1'b0;
      pci_irq_out <= 1'b0;
    end else begin
      local_irq_out <= |(pending & ~route_eff); // R21 R11
      pci_irq_out <= |(pending & route_eff); // R21 R11
    end
  end

  // Read mux; soft trigger bits and unmapped space read zero
  always_comb begin
    next_rdata = 32'h00000000;
    if (req.addr == OFS_STATUS) begin
      next_rdata = status;
    end else if (req.addr == OFS_ENABLE_CTL) begin
      next_rdata = enable_eff & ~ENABLE_ALWAYS; // R9 R10
    end else if (req.addr == OFS_ROUTE_DIR) begin
      next_rdata = route_eff; // R12 R13
    end
  end

  // Read data held until the next read; ack is a one-cycle pulse
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata <= 32'h00000000;
      rack <= 1'b0;
    end else begin
      rack <= req.rd | req.wr;
      if (req.rd) begin
        rdata <= next_rdata;
      end
    end
  end

endmodule // bir_router

// ==== bench/bir_router_assertions.sv ====
// Checker for the router: register port timing and read map.
// Assumes one clock domain; bound to each bir_router.
`timescale 1ns/1ps
module bir_router_assertions (
  input wire logic ref_clk,
  input wire logic rst,
  input wire bir_pkg::bir_src_type src,
  input wire bir_pkg::bir_req_type req,
  input wire logic [31:0] rdata,
  input wire logic rack,
  input wire logic local_irq_out,
  input wire logic pci_irq_out
);
  import bir_pkg::*;
  default clocking dcb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Reads decoded per offset
  logic rd_stat, rd_ctl, rd_dir, rd_ctl2, rd_none;
  assign rd_stat = req.rd && req.addr == OFS_STATUS;
  assign rd_ctl = req.rd && req.addr == OFS_ENABLE_CTL;
  assign rd_dir = req.rd && req.addr == OFS_ROUTE_DIR;
  assign rd_ctl2 = req.rd && req.addr == OFS_ENABLE_CTL2;
  assign rd_none = req.rd && !(req.addr inside {12'h600, 12'h604, 12'h608, 12'h60c});
  property p_ack; (req.wr || req.rd) |=> rack; endproperty
  a_ack: assert property (p_ack) else $error("rack missing");
  property p_ack_once; !(req.wr || req.rd) |=> !rack; endproperty
  a_ack_once: assert property (p_ack_once) else $error("rack without request");
  property p_ctl; rd_ctl |=> rdata[7:0] == 8'h00; endproperty
  a_ctl: assert property (p_ctl) else $error("soft trigger bits read back");
  property p_opm; rd_ctl |=> rdata[13] == !$past(src.out_post_irq_mask); endproperty
  a_opm: assert property (p_opm) else $error("out-post enable wrong");
  property p_dir; rd_dir |=> (rdata & ~ROUTE_WR_MASK) == ROUTE_FIXED_ONE; endproperty
  a_dir: assert property (p_dir) else $error("fixed route bits wrong");
  property p_ctl2; rd_ctl2 |=> rdata == 32'h0; endproperty
  a_ctl2: assert property (p_ctl2) else $error("second control not zero");
  property p_none; rd_none |=> rdata == 32'h0; endproperty
  a_none: assert property (p_none) else $error("unmapped read not zero");
  // Flag fields sit at src[5:1]: out-post, in-free, out-free, in-post-full, out-free-full
  property p_queue; rd_stat |=> {rdata[13], rdata[11:8]} == $past(src[5:1]); endproperty
  a_queue: assert property (p_queue) else $error("list flags not live");
  property p_set; src.dma_done ##1 !req.wr ##1 rd_stat |=> rdata[BIT_DMA_DONE]; endproperty
  a_set: assert property (p_set) else $error("event status not set");
  c_set: cover property (src.dma_done ##1 !req.wr ##1 rd_stat);
  c_local: cover property ($rose(local_irq_out));
  c_pci: cover property ($rose(pci_irq_out));
endmodule // bir_router_assertions

bind bir_router bir_router_assertions i_bir_router_assertions (.ref_clk(ref_clk), .rst(rst),
  .src(src), .req(req), .rdata(rdata), .rack(rack), .local_irq_out(local_irq_out),
  .pci_irq_out(pci_irq_out));

// ==== bench/bir_src_model.sv ====
// Far side model: the rest of the bridge feeding interrupt sources.
// Assumes the bench sets want just after each rising edge.
`timescale 1ns/1ps
module bir_src_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire bir_pkg::bir_src_type want,
  output bir_pkg::bir_src_type src
);
  import bir_pkg::*;
  // Lists start empty and out-post masked; source bits drop only when the handler says
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      src <= 25'h0000019;
    end else begin
      src <= want;
    end
  end
endmodule // bir_src_model

// ==== bench/test_bir_router.sv ====
// Testbench of the router: register map, sticky status and routing.
// Assumes the source model as far side; reads note expectations in a queue.
`timescale 1ns/1ps
module test_bir_router;
  import bir_pkg::*;
  logic ref_clk, rst, rack, local_irq_out, pci_irq_out;
  bir_src_type want, src;
  bir_req_type req;
  logic [31:0] rdata, r;
  logic [63:0] note;
  logic [63:0] q[$];
  int n_fail, samples_checked, cycles;
  int sb[11] = '{16, 13, 15, 8, 14, 17, 24, 9, 7, 6, 22};
  int stb[11] = '{23, 20, 22, 15, 21, 24, 31, 16, 14, 12, 29};
  bir_router i_bir_router (.ref_clk(ref_clk), .rst(rst), .src(src), .req(req),
    .rdata(rdata), .rack(rack), .local_irq_out(local_irq_out), .pci_irq_out(pci_irq_out));
  bir_src_model i_bir_src_model (.ref_clk(ref_clk), .rst(rst), .want(want), .src(src));
  // 40 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wrap_up();
    if (n_fail == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // One request per cycle; every request leaves a note, writes with an empty mask
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [31:0] e = 32'h0, input logic [31:0] m = 32'h0);
    req = '{w, !w, a, d};
    q.push_back({e & m, m});
    @(posedge ref_clk);
    #2;
  endtask
  task automatic step(input int n);
    req = '0;
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  task automatic irq(input logic l, input logic p);
    chk("local_irq_out", {31'h0, l}, {31'h0, local_irq_out});
    chk("pci_irq_out", {31'h0, p}, {31'h0, pci_irq_out});
  endtask
  // Each acknowledge retires the oldest note
  always @(negedge ref_clk) begin
    if (rack === 1'b1) begin
      note = q.pop_front();
      if (note[31:0] != 32'h0) chk("rdata", note[63:32], rdata & note[31:0]);
    end
  end
  // Hang guard, far above the few hundred cycles needed
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      wrap_up();
    end
  end
  initial begin
    rst = 1'b1;
    req = '0;
    want = 25'h0000019;
    void'($urandom(32'h687e6293));
    repeat (10) @(posedge ref_clk);
    #2;
    rst = 1'b0;
    acc(0, OFS_STATUS, 0, 32'h00000c00, '1);
    acc(0, OFS_ENABLE_CTL, 0, ENABLE_RESET, '1);
    acc(0, OFS_ROUTE_DIR, 0, ROUTE_FIXED_ONE, '1);
    acc(0, 12'h700, 0, 32'h0, '1);
    // Random patterns; read-only bits must not move
    repeat (4) begin
      r = $urandom;
      acc(1, OFS_ROUTE_DIR, r);
      acc(0, OFS_ROUTE_DIR, 0, (r & ROUTE_WR_MASK) | ROUTE_FIXED_ONE, '1);
      acc(1, OFS_ENABLE_CTL, r);
      acc(0, OFS_ENABLE_CTL, 0, r & ENABLE_WR_MASK, '1);
    end
    // Soft interrupts: no enable, split across both outputs
    want = 25'h0000001;
    acc(1, OFS_ENABLE_CTL, 32'h0);
    acc(1, OFS_STATUS, '1);
    acc(1, OFS_ROUTE_DIR, 32'h5);
    acc(0, OFS_STATUS, 0, 32'h0, '1);
    acc(1, OFS_ENABLE_CTL, 32'h1);
    acc(0, OFS_ENABLE_CTL2, 0, 32'h0, '1);
    step(1);
    irq(0, 1);
    acc(1, OFS_ENABLE_CTL2, 32'hc);
    acc(1, OFS_ENABLE_CTL, 32'h2);
    acc(1, OFS_STATUS, 32'h0);
    step(1);
    irq(1, 1);
    acc(0, OFS_STATUS, 0, 32'hf, 32'hf);
    acc(1, OFS_STATUS, 32'hf);
    step(2);
    irq(0, 0);
    // Eleven sources each alone, enables off then on; two of them need their enable
    acc(1, OFS_ROUTE_DIR, 32'h0);
    for (int en = 0; en < 2; en++) begin
      acc(1, OFS_ENABLE_CTL, en ? 32'hfffffffc : 32'h0);
      foreach (sb[i]) begin
        want = want | (25'h1 << sb[i]);
        step(1);
        want = 25'h0000001;
        step(2);
        irq(en && stb[i] != 20, en && stb[i] == 20);
        r = 32'h1 << stb[i];
        acc(0, OFS_STATUS, 0, (en || i < 9) ? r : 32'h0, r);
        acc(1, OFS_STATUS, r);
        step(2);
        irq(0, 0);
      end
    end
    // Parity status re-sets while the config bit stays up
    want = 25'h0400001;
    step(2);
    acc(1, OFS_STATUS, 32'h20000000);
    acc(0, OFS_STATUS, 0, 32'h20000000, 32'h20000000);
    want = 25'h0000001;
    step(1);
    acc(1, OFS_STATUS, 32'h20000000);
    acc(0, OFS_STATUS, 0, 32'h0, 32'h20000000);
    // Live list flags, out-post unmasked
    want = 25'h0000026;
    step(3);
    irq(1, 1);
    acc(0, OFS_STATUS, 0, 32'h2300, 32'h2300);
    acc(0, OFS_ENABLE_CTL, 0, 32'h2000, 32'h2000);
    want = 25'h0000001;
    step(3);
    irq(0, 0);
    // Second reset in mid-run
    rst = 1'b1;
    step(2);
    rst = 1'b0;
    acc(0, OFS_ENABLE_CTL, 0, ENABLE_RESET, '1);
    step(2);
    // Every request must have drawn exactly one acknowledge
    chk("notes left", 32'h0, q.size());
    wrap_up();
  end
endmodule // test_bir_router
